// ---- verilog/psf_framer.v ----
`timescale 1ns/1ps
`include "psf_defines.vh"

// Notes on behaviour
// - 28-bit frame: pixels, syncs, control, parity
// - payload scrambled and dc-balanced before sending
// - frame layout differs per payload mode
// - control bit rides every frame, video or not
// - frame rate is pclk over 1, 2, 1.5
// - line rate equals frame rate times 28
// - one parity bit in every frame
// - check back-channel crc, count mismatches
// - error count readable at backchannel_crc_error_count_a and backchannel_crc_error_count_b
// - forwarded outputs skew at most 25 us
// - each output mirrors remote or local bit, except outputs 2 and 3 in external oscillator mode
// - general outputs never forwarded as inputs
// - external oscillator on output 3, halved on 2
// - latch edge: 1 rising, 0 falling
// - internal oscillator keeps link, relock on pclk
// - power-down low holds serial outputs high
// - edge select is bit 0 of 0x03
module psf_framer (
    input  wire        clk_sys_in,             // system clock, 40 MHz
    input  wire        rst_n_in,               // sync reset, active low
    input  wire [7:0]  addr_in,                // register address
    input  wire [7:0]  wdata_in,               // register write data
    input  wire        wr_in,                  // write strobe
    input  wire        rd_in,                  // read strobe
    output reg  [7:0]  rdata_out,              // read data, cycle after rd
    input  wire        pclk_in,                // imager pixel clock pin
    input  wire [11:0] pix_data_in,            // pixel bus pins
    input  wire        line_sync_in,           // line sync pin
    input  wire        frame_sync_in,          // frame sync pin
    input  wire        power_down_n_in,        // power-down pin, low = off
    input  wire        ext_osc_mode_in,        // external oscillator mode pin
    input  wire        fwd_cc_bit_in,          // next forward control bit
    output reg         fwd_cc_taken_out,       // control bit consumed
    input  wire [19:0] bc_frame_in,            // back-channel frame
    input  wire        bc_valid_in,            // back-channel frame valid
    output reg  [27:0] frame_out,              // forward frame to serdes
    output reg         frame_strobe_out,       // one pulse per frame
    output reg         link_active_out,        // link enabled
    output reg         general_output_0_out,   // general output 0
    output reg         general_output_1_out,   // general output 1
    output reg         general_output_2_out,   // general output 2
    input  wire        general_output_3_in,    // pin 3 level (osc input)
    output reg         general_output_3_out,   // general output 3
    output reg         general_output_3_oe_out // pin 3 driven
);
    localparam ST_DOWN   = 2'd0;
    localparam ST_OSC    = 2'd1;
    localparam ST_RELOCK = 2'd2;
    localparam ST_VIDEO  = 2'd3;

    reg  [17:0] sync1_q;
    reg  [17:0] sync2_q;
    reg  [1:0]  prev_q;
    reg  [7:0]  cfg_q;
    reg  [1:0]  mode_q;
    reg  [7:0]  gpo_q;
    reg  [15:0] err_cnt_q;
    reg  [3:0]  remote_q;
    reg  [9:0]  stale_cnt_q;
    reg  [1:0]  state_q;
    reg  [6:0]  loss_cnt_q;
    reg  [4:0]  relock_cnt_q;
    reg  [4:0]  osc_cnt_q;
    reg  [41:0] acc_q;
    reg  [1:0]  pix_cnt_q;
    reg  [15:0] lfsr_q;
    reg         rd_pos_q;
    reg         xclk_div_q;

    wire        pclk_s = sync2_q[14];
    wire        osc_s  = sync2_q[17];
    wire        ext_s  = sync2_q[16];
    wire        pdn_s  = sync2_q[15];
    wire [13:0] sample = sync2_q[13:0];
    wire        p_rise = pclk_s & ~prev_q[0];
    wire        p_fall = ~pclk_s & prev_q[0];
    wire        osc_rise = osc_s & ~prev_q[1];
    wire        latch  = cfg_q[`PSF_CFG_EDGE_BIT] ? p_rise : p_fall;
    wire        lost   = (loss_cnt_q == `PSF_PCLK_LOSS_CYC);
    wire        stale  = (stale_cnt_q == `PSF_GPIO_SKEW_CYC);
    wire [41:0] acc_d  = {acc_q[27:0], sample};
    wire [3:0]  crc_calc;
    wire        bc_bad = bc_valid_in && (crc_calc != bc_frame_in[3:0]);

    reg         emit;
    reg  [24:0] payload;
    reg  [1:0]  pix_cnt_d;
    reg  [25:0] body;
    reg  [4:0]  ones;
    reg  [4:0]  sent_ones;
    reg         inv;
    reg  [26:0] word27;

    function [4:0] ones26;
        input [25:0] v;
        integer i;
        begin
            ones26 = 5'd0;
            for (i = 0; i < 26; i = i + 1) begin
                ones26 = ones26 + {4'h0, v[i]};
            end
        end
    endfunction

    // crc check of the back-channel payload
    psf_crc4 #(
        .W (16)
    ) u_crc (
        .data_in (bc_frame_in[19:4]),
        .crc_out (crc_calc)
    );

    // every pin passes two flops; data and clock share one skew
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            sync1_q <= 18'h0;
            sync2_q <= 18'h0;
            prev_q  <= 2'h0;
        end else begin
            sync1_q <= {general_output_3_in, ext_osc_mode_in, power_down_n_in,
                        pclk_in, line_sync_in, frame_sync_in, pix_data_in};
            sync2_q <= sync1_q;
            prev_q  <= {osc_s, pclk_s};
        end
    end

    // mode-dependent packing; pclk edges beyond half the system rate are lost
    always @* begin
        emit      = 1'b0;
        payload   = 25'h0;
        pix_cnt_d = pix_cnt_q;
        if (state_q == ST_VIDEO) begin
            if (latch) begin
                case (mode_q)
                    `PSF_MODE_10B: begin
                        // two pixels per frame, top data bits dropped
                        pix_cnt_d = (pix_cnt_q == 2'd1) ? 2'd0 : 2'd1;
                        emit      = (pix_cnt_q == 2'd1);
                        payload   = {1'b0, acc_d[27:26], acc_d[23:14],
                                     acc_d[13:12], acc_d[9:0]};
                    end
                    `PSF_MODE_HF: begin
                        // three pixels spread over two frames
                        pix_cnt_d = (pix_cnt_q == 2'd2) ? 2'd0 : pix_cnt_q + 2'd1;
                        emit      = (pix_cnt_q != 2'd0);
                        payload   = (pix_cnt_q == 2'd1) ? {4'h0, acc_d[27:7]}
                                                        : {4'h0, acc_d[20:0]};
                    end
                    default: begin
                        // one pixel with both syncs per frame
                        pix_cnt_d = 2'd0;
                        emit      = 1'b1;
                        payload   = {11'h0, sample};
                    end
                endcase
            end
        end else if (state_q != ST_DOWN) begin
            emit = (osc_cnt_q == `PSF_INT_OSC_DIV - 5'd1);
        end
    end

    // scramble, balance against running disparity, add parity
    always @* begin
        body      = {fwd_cc_bit_in, payload ^ {lfsr_q[8:0], lfsr_q}};
        ones      = ones26(body);
        inv       = (ones != `PSF_BODY_HALF) &&
                    ((ones > `PSF_BODY_HALF) == rd_pos_q);
        sent_ones = inv ? (5'd26 - ones) : ones;
        word27    = {inv, inv ? ~body : body};
    end

    // link state: down, internal oscillator, relock, video
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            state_q      <= ST_DOWN;
            loss_cnt_q   <= 7'h0;
            relock_cnt_q <= 5'h0;
            osc_cnt_q    <= 5'h0;
        end else begin
            if (p_rise | p_fall) begin
                loss_cnt_q <= 7'h0;
            end else if (!lost) begin
                loss_cnt_q <= loss_cnt_q + 7'h1;
            end
            osc_cnt_q <= (emit || state_q == ST_VIDEO) ? 5'h0 : osc_cnt_q + 5'h1;
            case (state_q)
                ST_DOWN: begin
                    if (pdn_s) begin
                        state_q <= ST_OSC;
                    end
                end
                ST_OSC: begin
                    relock_cnt_q <= 5'h0;
                    if (!pdn_s) begin
                        state_q <= ST_DOWN;
                    end else if (latch) begin
                        state_q <= ST_RELOCK;
                    end
                end
                ST_RELOCK: begin
                    if (!pdn_s) begin
                        state_q <= ST_DOWN;
                    end else if (lost) begin
                        state_q <= ST_OSC;
                    end else if (latch) begin
                        relock_cnt_q <= relock_cnt_q + 5'h1;
                        if (relock_cnt_q == `PSF_RELOCK_EDGES - 5'd1) begin
                            state_q <= ST_VIDEO;
                        end
                    end
                end
                default: begin
                    if (!pdn_s) begin
                        state_q <= ST_DOWN;
                    end else if (lost) begin
                        state_q <= ST_OSC;
                    end
                end
            endcase
        end
    end

    // frame register; one strobe per frame, 28 line bits each
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            frame_out        <= {`PSF_FRAME_W{1'b1}};
            frame_strobe_out <= 1'b0;
            fwd_cc_taken_out <= 1'b0;
            link_active_out  <= 1'b0;
            acc_q            <= 42'h0;
            pix_cnt_q        <= 2'h0;
            lfsr_q           <= `PSF_LFSR_SEED;
            rd_pos_q         <= 1'b0;
        end else begin
            link_active_out  <= (state_q != ST_DOWN);
            frame_strobe_out <= emit;
            fwd_cc_taken_out <= emit;
            if (state_q != ST_VIDEO) begin
                pix_cnt_q <= 2'h0;
            end else if (latch) begin
                acc_q     <= acc_d;
                pix_cnt_q <= pix_cnt_d;
            end
            if (state_q == ST_DOWN) begin
                frame_out <= {`PSF_FRAME_W{1'b1}};
            end else if (emit) begin
                frame_out <= {^word27, word27};
                lfsr_q    <= {lfsr_q[14:0],
                              lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
                if (sent_ones != `PSF_BODY_HALF) begin
                    rd_pos_q <= (sent_ones > `PSF_BODY_HALF);
                end
            end
        end
    end

    // back-channel error count and remote pin values
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            err_cnt_q   <= 16'h0;
            remote_q    <= 4'h0;
            stale_cnt_q <= 10'h0;
        end else begin
            // saturate so a long burst never wraps to a small count
            if (bc_bad && err_cnt_q != 16'hffff) begin
                err_cnt_q <= err_cnt_q + 16'h1;
            end
            if (bc_valid_in && !bc_bad) begin
                remote_q    <= bc_frame_in[7:4];
                stale_cnt_q <= 10'h0;
            end else if (!stale) begin
                stale_cnt_q <= stale_cnt_q + 10'h1;
            end
        end
    end

    // general outputs: remote mirror or local bit, except 2 carries halved osc in ext mode; pin 3 released and low in ext mode
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            xclk_div_q              <= 1'b0;
            general_output_0_out    <= 1'b0;
            general_output_1_out    <= 1'b0;
            general_output_2_out    <= 1'b0;
            general_output_3_out    <= 1'b0;
            general_output_3_oe_out <= 1'b0;
        end else begin
            if (osc_rise) begin
                xclk_div_q <= ~xclk_div_q;
            end
            general_output_0_out <= gpo_q[0] ? gpo_q[4] : remote_q[0];
            general_output_1_out <= gpo_q[1] ? gpo_q[5] : remote_q[1];
            if (ext_s) begin
                general_output_2_out    <= xclk_div_q;
                general_output_3_out    <= 1'b0;
                general_output_3_oe_out <= 1'b0;
            end else begin
                general_output_2_out    <= gpo_q[2] ? gpo_q[6] : remote_q[2];
                general_output_3_out    <= gpo_q[3] ? gpo_q[7] : remote_q[3];
                general_output_3_oe_out <= 1'b1;
            end
        end
    end

    // register writes
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            cfg_q  <= `PSF_CFG_RST;
            mode_q <= `PSF_MODE_RST;
            gpo_q  <= `PSF_GPO_RST;
        end else if (wr_in) begin
            if (addr_in == `PSF_ADR_CFG) begin
                cfg_q <= wdata_in;
            end else if (addr_in == `PSF_ADR_MODE) begin
                mode_q <= wdata_in[1:0];
            end else if (addr_in == `PSF_ADR_GPO) begin
                gpo_q <= wdata_in;
            end
        end
    end

    // register reads, unmapped addresses read zero
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rdata_out <= 8'h0;
        end else begin
            rdata_out <= 8'h0;
            if (rd_in) begin
                if (addr_in == `PSF_ADR_CFG) begin
                    rdata_out <= cfg_q;
                end else if (addr_in == `PSF_ADR_MODE) begin
                    rdata_out <= {6'h0, mode_q};
                end else if (addr_in == `PSF_ADR_ERR_A) begin
                    rdata_out <= err_cnt_q[7:0];
                end else if (addr_in == `PSF_ADR_ERR_B) begin
                    rdata_out <= err_cnt_q[15:8];
                end else if (addr_in == `PSF_ADR_GPO) begin
                    rdata_out <= gpo_q;
                end else if (addr_in == `PSF_ADR_STAT) begin
                    rdata_out <= {4'h0, stale, ext_s, state_q == ST_VIDEO,
                                  state_q == ST_OSC || state_q == ST_RELOCK};
                end
            end
        end
    end
endmodule

// ---- pkg/psf_defines.vh ----
`ifndef PSF_DEFINES_VH
`define PSF_DEFINES_VH

// frame geometry
`define PSF_FRAME_W        28
`define PSF_PAY_W          25
`define PSF_BODY_W         26
`define PSF_BODY_HALF      5'd13
`define PSF_BC_W           20

// register offsets
`define PSF_ADR_CFG        8'h03
`define PSF_ADR_MODE       8'h04
`define PSF_ADR_ERR_A      8'h0a
`define PSF_ADR_ERR_B      8'h0b
`define PSF_ADR_GPO        8'h0d
`define PSF_ADR_STAT       8'h0e

// field positions and reset values
`define PSF_CFG_EDGE_BIT   0
`define PSF_CFG_RST        8'h01
`define PSF_MODE_RST       2'h0
`define PSF_GPO_RST        8'h00

// payload modes
`define PSF_MODE_LF        2'h0
`define PSF_MODE_10B       2'h1
`define PSF_MODE_HF        2'h2

// scrambler and back-channel check
`define PSF_LFSR_SEED      16'hace1
`define PSF_CRC_POLY       4'h3
`define PSF_CRC_INIT       4'hf

// timing
`define PSF_CLK_MHZ        40
`define PSF_GPIO_SKEW_US   25
`define PSF_GPIO_SKEW_CYC  (`PSF_GPIO_SKEW_US * `PSF_CLK_MHZ)
`define PSF_PCLK_LOSS_CYC  7'd64
`define PSF_RELOCK_EDGES   5'd16
`define PSF_INT_OSC_DIV    5'd28

`endif

// ---- verilog/psf_crc4.v ----
`timescale 1ns/1ps
`include "psf_defines.vh"

// crc-4 over a data word, msb first, purely combinational
module psf_crc4 #(
    parameter W = 16
) (
    input  wire [W-1:0] data_in,  // word to check
    output reg  [3:0]   crc_out   // computed remainder
);
    integer i;
    reg     fb;

    // shift each data bit through the polynomial register
    always @* begin
        crc_out = `PSF_CRC_INIT;
        fb      = 1'b0;
        for (i = W - 1; i >= 0; i = i - 1) begin
            fb      = data_in[i] ^ crc_out[3];
            crc_out = {crc_out[2:0], 1'b0} ^ (fb ? `PSF_CRC_POLY : 4'h0);
        end
    end
endmodule

// ---- dv/psf_framer_props.sv ----
`timescale 1ns/1ps
// pin-level checks on the framer; one clock domain
module psf_framer_props (
    input wire        clk_sys_in,             // system clock
    input wire        rst_n_in,               // sync reset
    input wire [7:0]  addr_in,                // address
    input wire        rd_in,                  // read strobe
    input wire [7:0]  rdata_out,              // read data
    input wire        power_down_n_in,        // power-down pin
    input wire        fwd_cc_bit_in,          // control bit offered
    input wire        fwd_cc_taken_out,       // control bit taken
    input wire [27:0] frame_out,              // forward frame
    input wire        frame_strobe_out,       // frame pulse
    input wire        link_active_out,        // link up
    input wire        general_output_3_out,   // output 3
    input wire        general_output_3_oe_out // output 3 enable
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // reads of holes in the map
    sequence s_hole_rd;
        rd_in && !(addr_in inside {8'h03, 8'h04, 8'h0a, 8'h0b, 8'h0d, 8'h0e});
    endsequence
    // pin low long enough to pass the synchroniser
    sequence s_pdn_low;
        !power_down_n_in [*4];
    endsequence
    property p_parity;
        frame_strobe_out |-> (^frame_out) == 1'b0;
    endproperty
    // the control bit survives balancing: body msb xor invert flag
    property p_cc;
        (frame_strobe_out == fwd_cc_taken_out) &&
        (!frame_strobe_out || (frame_out[26] ^ frame_out[25]) == $past(fwd_cc_bit_in));
    endproperty
    property p_down;
        !link_active_out |-> frame_out == 28'hfffffff && !frame_strobe_out;
    endproperty
    property p_pdn;
        s_pdn_low |=> !link_active_out;
    endproperty
    property p_up;
        $rose(link_active_out) |-> $past(power_down_n_in, 2);
    endproperty
    property p_rd_idle;
        !$past(rd_in) |-> rdata_out == 8'h00;
    endproperty
    property p_hole;
        s_hole_rd |=> rdata_out == 8'h00;
    endproperty
    property p_gap;
        frame_strobe_out |=> !frame_strobe_out;
    endproperty
    property p_oe;
        !general_output_3_oe_out |-> !general_output_3_out;
    endproperty
    a_parity: assert property (p_parity) else $error("frame parity odd");
    a_cc: assert property (p_cc) else $error("control bit not taken with frame");
    a_down: assert property (p_down) else $error("serial out not high while down");
    a_pdn: assert property (p_pdn) else $error("link up with power-down low");
    a_up: assert property (p_up) else $error("link rose without enable");
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    a_hole: assert property (p_hole) else $error("unmapped read not zero");
    a_gap: assert property (p_gap) else $error("frame strobe too long");
    a_oe: assert property (p_oe) else $error("pin 3 driven while released");
endmodule

// ---- dv/psf_deser_model.sv ----
`timescale 1ns/1ps
// far-end deserializer: checks forward parity, sends back-channel frames
module psf_deser_model (
    input  wire        clk_sys_in,    // system clock
    input  wire        rst_n_in,      // sync reset
    input  wire [27:0] frame_in,      // forward frame
    input  wire        strobe_in,     // frame valid
    input  wire        lock_in,       // link up
    input  wire        send_in,       // send one frame
    input  wire        bad_in,        // corrupt its crc
    input  wire [3:0]  pins_in,       // remote pin levels
    output reg  [19:0] bc_frame_out,  // back-channel frame
    output reg         bc_valid_out,  // frame valid pulse
    output reg  [7:0]  par_errs_out,  // parity error count
    output reg         integrity_out  // low on parity error
);
    // crc-4 x^4+x+1, init f, msb first
    function [3:0] crc4(input [15:0] d);
        integer i;
        begin
            crc4 = 4'hf;
            for (i = 15; i >= 0; i = i - 1) begin
                crc4 = {crc4[2:0], 1'b0} ^ ((crc4[3] ^ d[i]) ? 4'h3 : 4'h0);
            end
        end
    endfunction
    // pins travel only as slow back-channel frames; idle bus inverts the last frame every cycle
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            bc_frame_out <= 20'h00000;
            bc_valid_out <= 1'b0;
        end else if (send_in) begin
            bc_frame_out <= {12'h3c5, pins_in,
                             crc4({12'h3c5, pins_in}) ^ {3'h0, bad_in}};
            bc_valid_out <= 1'b1;
        end else begin
            bc_frame_out <= ~bc_frame_out;
            bc_valid_out <= 1'b0;
        end
    end
    // parity check, counters cleared whenever lock drops
    always @(posedge clk_sys_in) begin
        if (!rst_n_in || !lock_in) begin
            par_errs_out <= 8'h00;
            integrity_out <= 1'b1;
        end else if (strobe_in) begin
            par_errs_out <= par_errs_out + {7'h00, ^frame_in};
            integrity_out <= ~^frame_in;
        end
    end
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    reg         clk_sys_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
    reg  [7:0]  addr_in = 8'h00, wdata_in = 8'h00;
    reg  [11:0] pix_data_in = 12'h000;
    reg         pclk_in = 1'b0, line_sync_in = 1'b0, frame_sync_in = 1'b0;
    reg         power_down_n_in = 1'b0, ext_osc_mode_in = 1'b0, fwd_cc_bit_in = 1'b0;
    reg         general_output_3_in = 1'b0, send = 1'b0, bad = 1'b0;
    reg         pclk_run = 1'b0, ext_run = 1'b0, edge_chk = 1'b0, edge_lvl = 1'b1;
    reg  [3:0]  pins = 4'h0;
    reg  [27:0] cyc = 28'h0, last_at = 28'h0, last_gap = 28'h0, n_frames = 28'h0;
    reg  [27:0] n_tog = 28'h0, n0;
    reg         out2_q = 1'b0;
    integer     pc = 0, i, errors = 0, n_compared = 0;
    wire [7:0]  rdata_out, par_errs;
    wire [27:0] frame_out;
    wire [19:0] bc_frame_in;
    wire        fwd_cc_taken_out, frame_strobe_out, link_active_out, bc_valid_in;
    wire        general_output_0_out, general_output_1_out, general_output_2_out;
    wire        general_output_3_out, general_output_3_oe_out, integrity;
    wire [3:0]  gpo_w = {general_output_3_out, general_output_2_out,
                         general_output_1_out, general_output_0_out};

    psf_framer i_psf_framer (.*);
    psf_deser_model i_psf_deser_model (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .frame_in(frame_out), .strobe_in(frame_strobe_out), .lock_in(link_active_out),
        .send_in(send), .bad_in(bad), .pins_in(pins), .bc_frame_out(bc_frame_in),
        .bc_valid_out(bc_valid_in), .par_errs_out(par_errs), .integrity_out(integrity));

    always #12.5 clk_sys_in = ~clk_sys_in;

    // pixel clock of 12 cycles, held when stopped; syncs change rarely
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 28'h1;
        fwd_cc_bit_in <= cyc[3];
        general_output_3_in <= ext_run & cyc[2];
        if (pclk_run) begin
            pc <= (pc == 11) ? 0 : pc + 1;
            pclk_in <= (pc < 6);
            if (pc == 0) begin
                pix_data_in <= pix_data_in + 12'h001;
                line_sync_in <= pix_data_in[4];
                frame_sync_in <= pix_data_in[7];
            end
        end
    end

    // frame counting, gap timing, pixel clock phase at each frame
    always @(posedge clk_sys_in) begin
        out2_q <= general_output_2_out;
        if (general_output_2_out !== out2_q) n_tog <= n_tog + 28'h1;
        if (frame_strobe_out === 1'b1) begin
            n_frames <= n_frames + 28'h1;
            last_gap <= cyc - last_at;
            last_at <= cyc;
        end
        if (edge_chk && frame_strobe_out === 1'b1) begin
            n_compared = n_compared + 1;
            if (pclk_in !== edge_lvl) begin
                errors = errors + 1;
                $display("ERROR pclk phase: exp %0b got %0b", edge_lvl, pclk_in);
            end
        end
    end

    task chk(input string nm, input [27:0] e, input [27:0] g);
        begin
            n_compared = n_compared + 1;
            if (e !== g) begin
                errors = errors + 1;
                $display("ERROR %s: exp %0h got %0h", nm, e, g);
            end
        end
    endtask

    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_sys_in);
            addr_in <= a;
            wdata_in <= d;
            wr_in <= 1'b1;
            @(posedge clk_sys_in);
            wr_in <= 1'b0;
        end
    endtask

    // read data stands only in the cycle after the strobe
    task rd(input [7:0] a, input [7:0] e);
        begin
            @(posedge clk_sys_in);
            addr_in <= a;
            rd_in <= 1'b1;
            @(posedge clk_sys_in);
            rd_in <= 1'b0;
            #1;
            chk("rdata", {20'h0, e}, {20'h0, rdata_out});
            // leave on an edge so the next stimulus moves with the clock
            @(posedge clk_sys_in);
        end
    endtask

    task bc(input b, input [3:0] p);
        begin
            @(posedge clk_sys_in);
            send <= 1'b1;
            bad <= b;
            pins <= p;
        end
    endtask

    task wait_n(input integer n);
        begin
            repeat (n) @(posedge clk_sys_in);
        end
    endtask

    task wrap_up;
        begin
            $display("compared %0d, errors %0d", n_compared, errors);
            if (errors == 0 && n_compared > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    // about 2200 cycles expected
    initial begin
        #200000;
        errors = errors + 1;
        wrap_up;
    end

    initial begin
        wait_n(3);
        rst_n_in <= 1'b1;
        rd(8'h03, 8'h01);
        rd(8'h04, 8'h00);
        rd(8'h0a, 8'h00);
        rd(8'h0b, 8'h00);
        rd(8'h0d, 8'h00);
        rd(8'h55, 8'h00);
        wr(8'h0a, 8'hff);
        rd(8'h0a, 8'h00);
        chk("frame", 28'hfffffff, frame_out);
        chk("link", 28'h0, {27'h0, link_active_out});
        $display("test registers done");
        power_down_n_in <= 1'b1;
        wait_n(120);
        chk("link", 28'h1, {27'h0, link_active_out});
        rd(8'h0e, 8'h01);
        chk("osc gap", 28'd28, last_gap);
        bc(1'b0, 4'h6);
        for (i = 0; i < 3; i = i + 1) bc(1'b1, 4'hf);
        wait_n(1);
        send <= 1'b0;
        wait_n(4);
        rd(8'h0a, 8'h03);
        rd(8'h0b, 8'h00);
        chk("remote gpo", 28'h6, {24'h0, gpo_w});
        wr(8'h0d, 8'haf);
        wait_n(3);
        chk("local gpo", 28'ha, {24'h0, gpo_w});
        chk("oe3", 28'h1, {27'h0, general_output_3_oe_out});
        $display("test back channel done");
        pclk_run <= 1'b1;
        wait_n(400);
        edge_chk <= 1'b1;
        for (i = 0; i < 3; i = i + 1) begin
            wr(8'h04, i[7:0]);
            wait_n(60);
            n0 = n_frames;
            wait_n(288);
            chk("frames", (i == 0) ? 28'd24 : (i == 1) ? 28'd12 : 28'd16,
                n_frames - n0);
        end
        edge_chk <= 1'b0;
        wr(8'h03, 8'h00);
        rd(8'h03, 8'h00);
        wait_n(100);
        edge_lvl <= 1'b0;
        edge_chk <= 1'b1;
        wait_n(200);
        edge_chk <= 1'b0;
        chk("parity errors", 28'h0, {20'h0, par_errs});
        chk("integrity", 28'h1, {27'h0, integrity});
        rd(8'h0e, 8'h0a);
        $display("test video done");
        pclk_run <= 1'b0;
        wait_n(150);
        chk("osc gap", 28'd28, last_gap);
        ext_osc_mode_in <= 1'b1;
        ext_run <= 1'b1;
        wait_n(40);
        n0 = n_tog;
        wait_n(80);
        chk("osc half", 28'd10, n_tog - n0);
        chk("oe3", 28'h0, {27'h0, general_output_3_oe_out});
        rd(8'h0e, 8'h0d);
        power_down_n_in <= 1'b0;
        wait_n(10);
        chk("link", 28'h0, {27'h0, link_active_out});
        chk("frame", 28'hfffffff, frame_out);
        $display("test clocking done");
        wrap_up;
    end
endmodule

bind psf_framer psf_framer_props i_psf_framer_props (.*);
